//--- verilog/bcr_cfg.svh
// Purpose: Constants of the bar code serial receiver
// Assumes: 40 MHz clock, 16x oversampling
// Notes: Register map on AHB-Lite, word aligned
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH

`define BCR_CLK_HZ 40000000
`define BCR_OVS 16
`define BCR_DIV_4800 10'((`BCR_CLK_HZ) / (`BCR_OVS * 4800))
`define BCR_DIV_9600 10'((`BCR_CLK_HZ) / (`BCR_OVS * 9600))
`define BCR_DIV_19200 10'((`BCR_CLK_HZ) / (`BCR_OVS * 19200))
`define BCR_PH_MID 4'h7
`define BCR_PH_LAST 4'hf
`define BCR_NB_7 4'h6
`define BCR_NB_8 4'h7

`define BCR_OFF_CTRL 8'h00
`define BCR_OFF_STAT 8'h04
`define BCR_OFF_ACK 8'h08
`define BCR_OFF_DATA 8'h40
`define BCR_OFF_DEND 8'he0

`define BCR_CB_DATA8 0
`define BCR_CB_STOP1 1
`define BCR_CB_PAR 3:2
`define BCR_CB_SPD 5:4
`define BCR_CB_AUTO 6
`define BCR_CB_EN 7
`define BCR_CTRL_RST 8'h18

`define BCR_STX 8'h02
`define BCR_ETX 8'h03
`define BCR_CH_MIN 8'h20
`define BCR_CH_MAX 8'h7f
`define BCR_MAXLEN 6'h28

`endif

//--- verilog/bcr_pkg.sv
// Purpose: Types of the bar code serial receiver
// Assumes: Constants live in bcr_cfg.svh
// Notes: Encodings match the control register fields
package bcr_pkg;

   typedef enum logic [1:0] {
      BCR_PAR_NONE = 2'b00,
      BCR_PAR_ODD = 2'b01,
      BCR_PAR_EVEN = 2'b10
   } bcr_par_t;

   typedef enum logic [1:0] {
      BCR_SPD_4800 = 2'b00,
      BCR_SPD_9600 = 2'b01,
      BCR_SPD_19200 = 2'b10
   } bcr_spd_t;

   typedef enum logic [2:0] {
      BCR_RX_IDLE = 3'b000,
      BCR_RX_START = 3'b001,
      BCR_RX_DATA = 3'b010,
      BCR_RX_PAR = 3'b011,
      BCR_RX_STOP = 3'b100
   } bcr_rx_st_t;

   typedef enum logic [0:0] {
      BCR_F_WAIT = 1'b0,
      BCR_F_BODY = 1'b1
   } bcr_fr_st_t;

endpackage : bcr_pkg

//--- verilog/bcr_baud.sv
// Purpose: Oversampling tick for the serial line
// Assumes: Speed code from the control register
// Notes: New speed takes effect at the next wrap
`timescale 1ns/100ps
`include "bcr_cfg.svh"
module bcr_baud
   import bcr_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [1:0] spd_in,
   output logic tick_out
);
   typedef struct packed {
      logic [9:0] cnt;
      logic tick;
   } bcr_baud_st_t;

   bcr_baud_st_t s_q;
   bcr_baud_st_t s_d;

   function automatic logic [9:0] div_of(input logic [1:0] spd);
      unique case (spd)
         BCR_SPD_4800: div_of = `BCR_DIV_4800;
         BCR_SPD_19200: div_of = `BCR_DIV_19200;
         default: div_of = `BCR_DIV_9600;
      endcase
   endfunction : div_of

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == 10'h000) begin
         s_d.cnt = div_of(spd_in) - 10'h001;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt - 10'h001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_out = s_q.tick;
endmodule : bcr_baud

//--- verilog/bcr_rx.sv
// Purpose: Character receiver, 7/8 data bits, parity, 1/2 stops
// Assumes: Line idles high; tick is 16x the bit rate
// Notes: Parity or stop faults mark the character bad
`timescale 1ns/100ps
`include "bcr_cfg.svh"
module bcr_rx
   import bcr_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic tick_in,
   input wire logic rxd_in,
   input wire logic data8_in,
   input wire logic stop1_in,
   input wire logic [1:0] par_in,
   output logic stb_out,
   output logic [7:0] byte_out,
   output logic err_out
);
   typedef struct packed {
      bcr_rx_st_t st;
      logic [3:0] ph;
      logic [3:0] nb;
      logic [7:0] sh;
      logic stp;
      logic err;
      logic stb;
      logic berr;
      logic [7:0] dat;
   } bcr_rx_st2_t;

   bcr_rx_st2_t s_q;
   bcr_rx_st2_t s_d;
   logic [7:0] dbyte;

   // Seven-bit characters end one place higher in the shifter
   assign dbyte = data8_in ? s_q.sh : {1'b0, s_q.sh[7:1]};

   always_comb begin
      s_d = s_q;
      s_d.stb = 1'b0;
      if (tick_in) begin
         s_d.ph = s_q.ph + 4'h1;
         unique case (s_q.st)
            BCR_RX_IDLE: begin
               s_d.ph = 4'h0;
               if (!rxd_in) s_d.st = BCR_RX_START;
            end
            BCR_RX_START: if (s_q.ph == `BCR_PH_MID) begin
               // Glitch shorter than half a bit is dropped
               s_d.ph = 4'h0;
               s_d.nb = 4'h0;
               s_d.err = 1'b0;
               s_d.st = rxd_in ? BCR_RX_IDLE : BCR_RX_DATA;
            end
            BCR_RX_DATA: if (s_q.ph == `BCR_PH_LAST) begin
               s_d.sh = {rxd_in, s_q.sh[7:1]};
               s_d.nb = s_q.nb + 4'h1;
               s_d.stp = !stop1_in;
               if (s_q.nb == (data8_in ? `BCR_NB_8 : `BCR_NB_7)) begin
                  s_d.st = (par_in == BCR_PAR_NONE) ? BCR_RX_STOP : BCR_RX_PAR;
               end
            end
            BCR_RX_PAR: if (s_q.ph == `BCR_PH_LAST) begin
               if ((^dbyte ^ rxd_in) != (par_in == BCR_PAR_ODD)) s_d.err = 1'b1;
               s_d.st = BCR_RX_STOP;
            end
            BCR_RX_STOP: if (s_q.ph == `BCR_PH_LAST) begin
               if (s_q.stp) begin
                  s_d.stp = 1'b0;
                  s_d.err = s_q.err | !rxd_in;
               end else begin
                  s_d.st = BCR_RX_IDLE;
                  s_d.stb = 1'b1;
                  s_d.dat = dbyte;
                  s_d.berr = s_q.err | !rxd_in;
               end
            end
            default: s_d.st = BCR_RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign stb_out = s_q.stb;
   assign byte_out = s_q.dat;
   assign err_out = s_q.berr;
endmodule : bcr_rx

//--- verilog/bcr_top.sv
// Purpose: Bar code serial receiver with AHB-Lite registers
// Assumes: One 40 MHz clock, synchronous active-low reset
// Notes: Zero-wait slave; payload read back word per byte
//
// Overview of operation
// - Seven or eight data bits; seven after reset.
// - One or two stop bits; two after reset.
// - Parity none, odd or even; even after reset.
// - Line speed 4800, 9600 or 19200 bps; 9600 after reset.
// - Input mode manual or automatic; manual after reset.
// - Frame is STX 02h, data characters, then ETX 03h.
// - Payload characters must lie within 20h to 7Fh.
// - Payload holds at most 40 bytes.
// - Frames breaking format, range or length are discarded silently.
// - Drive receive permit to the reader; watch its send permit.
// - Automatic mode drops receive permit until the string is reported.
// - New frames overwrite pending data even if not yet reported.
// - Reception works only when the port is set for the reader.
`timescale 1ns/100ps
`include "bcr_cfg.svh"
module bcr_top
   import bcr_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic rxd_in,
   input wire logic send_permit_in,
   output logic receive_permit_out,
   output logic str_valid_out,
   output logic [5:0] str_len_out,
   output logic [319:0] str_data_out,
   input wire logic str_ack_in
);
   typedef struct packed {
      logic [7:0] ctrl;
      bcr_fr_st_t fst;
      logic [5:0] cnt;
      logic [39:0][7:0] work;
      logic [39:0][7:0] held;
      logic [5:0] len;
      logic pend;
      logic [7:0] drop;
      logic dact;
      logic dwr;
      logic [7:0] daddr;
      logic [31:0] rdata;
   } bcr_top_st_t;

   bcr_top_st_t s_q;
   bcr_top_st_t s_d;

   logic tick;
   logic rx_stb;
   logic [7:0] rx_byte;
   logic rx_err;
   logic en;
   logic auto_md;
   logic commit;
   logic bus_ack;
   logic ack;
   logic byte_ok;

   assign en = s_q.ctrl[`BCR_CB_EN];
   assign auto_md = s_q.ctrl[`BCR_CB_AUTO];

   bcr_baud u_baud (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .spd_in(s_q.ctrl[`BCR_CB_SPD]),
      .tick_out(tick)
   );

   bcr_rx u_rx (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .tick_in(tick),
      .rxd_in(rxd_in),
      .data8_in(s_q.ctrl[`BCR_CB_DATA8]),
      .stop1_in(s_q.ctrl[`BCR_CB_STOP1]),
      .par_in(s_q.ctrl[`BCR_CB_PAR]),
      .stb_out(rx_stb),
      .byte_out(rx_byte),
      .err_out(rx_err)
   );

   // Read value of a register, captured in the address phase
   function automatic logic [31:0] rd_word(input logic [7:0] a, input bcr_top_st_t s);
      logic [5:0] idx;
      idx = 6'((a - `BCR_OFF_DATA) >> 2);
      rd_word = 32'h0000_0000;
      if (a == `BCR_OFF_CTRL) begin
         rd_word[7:0] = s.ctrl;
      end else if (a == `BCR_OFF_STAT) begin
         rd_word[0] = s.pend;
         rd_word[1] = send_permit_in;
         rd_word[2] = receive_permit_out;
         rd_word[13:8] = s.len;
         rd_word[23:16] = s.drop;
      end else if (a >= `BCR_OFF_DATA && a < `BCR_OFF_DEND) begin
         rd_word[7:0] = s.held[idx];
      end
   endfunction : rd_word

   assign byte_ok = rx_byte >= `BCR_CH_MIN && rx_byte <= `BCR_CH_MAX;

   always_comb begin
      s_d = s_q;
      commit = 1'b0;
      bus_ack = 1'b0;
      s_d.dact = hsel_in && htrans_in[1] && hready_in;
      if (s_d.dact) begin
         s_d.dwr = hwrite_in;
         s_d.daddr = haddr_in[7:0];
         s_d.rdata = rd_word(haddr_in[7:0], s_q);
      end
      if (s_q.dact && s_q.dwr) begin
         if (s_q.daddr == `BCR_OFF_CTRL) s_d.ctrl = hwdata_in[7:0];
         if (s_q.daddr == `BCR_OFF_ACK) bus_ack = hwdata_in[0];
      end
      if (!en) begin
         s_d.fst = BCR_F_WAIT;
         s_d.cnt = 6'h00;
      end else if (rx_stb) begin
         unique case (s_q.fst)
            BCR_F_WAIT: if (!rx_err && rx_byte == `BCR_STX) begin
               s_d.fst = BCR_F_BODY;
               s_d.cnt = 6'h00;
            end
            BCR_F_BODY: begin
               if (!rx_err && rx_byte == `BCR_ETX) begin
                  commit = 1'b1;
                  s_d.fst = BCR_F_WAIT;
               end else if (!rx_err && byte_ok && s_q.cnt < `BCR_MAXLEN) begin
                  s_d.work[s_q.cnt] = rx_byte;
                  s_d.cnt = s_q.cnt + 6'h01;
               end else begin
                  // Bad character or overlength: whole frame goes
                  s_d.fst = BCR_F_WAIT;
                  s_d.drop = s_q.drop + 8'h01;
               end
            end
         endcase
      end
      ack = str_ack_in | bus_ack;
      if (ack) s_d.pend = 1'b0;
      // Commit after ack so a new string is never lost
      if (commit) begin
         s_d.held = s_q.work;
         s_d.len = s_q.cnt;
         s_d.pend = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         s_q <= '0;
         s_q.ctrl <= `BCR_CTRL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Manual mode withholds permission only while the port is disabled; auto waits for the host
   assign receive_permit_out = en && !(auto_md && s_q.pend);
   assign str_valid_out = s_q.pend;
   assign str_len_out = s_q.len;
   assign str_data_out = s_q.held;
   assign hrdata_out = s_q.rdata;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   default clocking bcr_cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   property p_ctrl_rst;
      !$past(resetn_in) |-> s_q.ctrl == `BCR_CTRL_RST;
   endproperty
   a_ctrl_rst: assert property (p_ctrl_rst)
      else $error("control register not at default after reset");

   property p_auto_block;
      en && auto_md && str_valid_out |-> !receive_permit_out;
   endproperty
   a_auto_block: assert property (p_auto_block)
      else $error("receive permit high while auto string pending");

   property p_manual_open;
      en && !auto_md |-> receive_permit_out;
   endproperty
   a_manual_open: assert property (p_manual_open)
      else $error("receive permit low in manual mode");

   property p_off_idle;
      !en |-> !receive_permit_out ##1 s_q.fst == BCR_F_WAIT;
   endproperty
   a_off_idle: assert property (p_off_idle)
      else $error("receiver active while port not set for reader");

   property p_stx_start;
      en && rx_stb && !rx_err && rx_byte == `BCR_STX && s_q.fst == BCR_F_WAIT
         |=> s_q.fst == BCR_F_BODY && s_q.cnt == 6'h00;
   endproperty
   a_stx_start: assert property (p_stx_start)
      else $error("start character did not open a frame");

   property p_range_drop;
      en && rx_stb && s_q.fst == BCR_F_BODY && !byte_ok && rx_byte != `BCR_ETX
         |=> s_q.fst == BCR_F_WAIT && s_q.drop == $past(s_q.drop) + 8'h01;
   endproperty
   a_range_drop: assert property (p_range_drop)
      else $error("out of range character not discarded");

   property p_len_cap;
      en && rx_stb && s_q.fst == BCR_F_BODY && s_q.cnt == `BCR_MAXLEN
         && rx_byte != `BCR_ETX |=> s_q.fst == BCR_F_WAIT;
   endproperty
   a_len_cap: assert property (p_len_cap)
      else $error("payload accepted past maximum length");

   property p_len_max;
      str_len_out <= `BCR_MAXLEN && s_q.cnt <= `BCR_MAXLEN;
   endproperty
   a_len_max: assert property (p_len_max)
      else $error("length beyond maximum");

   property p_no_drop_commit;
      $changed(s_q.drop) |-> !str_valid_out || !$rose(str_valid_out);
   endproperty
   a_no_drop_commit: assert property (p_no_drop_commit)
      else $error("discarded frame was delivered");

   property p_commit;
      commit |=> str_valid_out && str_len_out == $past(s_q.cnt)
         && str_data_out == $past(s_q.work);
   endproperty
   a_commit: assert property (p_commit)
      else $error("accepted string not presented");

   property p_ack;
      ack && !commit |=> !str_valid_out;
   endproperty
   a_ack: assert property (p_ack)
      else $error("acknowledge did not clear valid");

   property p_overwrite;
      commit && str_valid_out |=> str_valid_out ##0 str_len_out == $past(s_q.cnt);
   endproperty
   a_overwrite: assert property (p_overwrite)
      else $error("pending string not overwritten");

   property p_ahb_read;
      s_d.dact && !hwrite_in && haddr_in[7:0] == `BCR_OFF_CTRL
         |=> hrdata_out[7:0] == $past(s_q.ctrl);
   endproperty
   a_ahb_read: assert property (p_ahb_read)
      else $error("control readback wrong");

   property p_etx_commit;
      en && rx_stb && !rx_err && rx_byte == `BCR_ETX && s_q.fst == BCR_F_BODY
         |=> str_valid_out && s_q.fst == BCR_F_WAIT;
   endproperty
   a_etx_commit: assert property (p_etx_commit)
      else $error("end character did not deliver the string");

   property p_wait_ignore;
      en && rx_stb && s_q.fst == BCR_F_WAIT && (rx_err || rx_byte != `BCR_STX)
         |=> s_q.fst == BCR_F_WAIT && $stable(s_q.drop);
   endproperty
   a_wait_ignore: assert property (p_wait_ignore)
      else $error("character outside a frame was not ignored");

   property p_err_drop;
      en && rx_stb && rx_err && s_q.fst == BCR_F_BODY
         |=> s_q.fst == BCR_F_WAIT && s_q.drop == $past(s_q.drop) + 8'h01;
   endproperty
   a_err_drop: assert property (p_err_drop)
      else $error("character with line error not discarded");

   property p_held_stable;
      !commit
         |=> $stable(str_data_out) && $stable(str_len_out);
   endproperty
   a_held_stable: assert property (p_held_stable)
      else $error("held string changed without a commit");

   property p_body_count;
      en && rx_stb && s_q.fst == BCR_F_BODY && !rx_err && byte_ok && s_q.cnt < `BCR_MAXLEN
         |=> s_q.cnt == $past(s_q.cnt) + 6'h01;
   endproperty
   a_body_count: assert property (p_body_count)
      else $error("payload character not counted");

   property p_stat_read;
      s_d.dact && !hwrite_in && haddr_in[7:0] == `BCR_OFF_STAT
         |=> hrdata_out[1] == $past(send_permit_in);
   endproperty
   a_stat_read: assert property (p_stat_read)
      else $error("send permit not shown in status");
endmodule : bcr_top

//--- verification/bcr_reader.sv
// Purpose: Behavioural bar code reader on the serial line
// Assumes: Bit time given in system clocks; line idles high
// Notes: Sends only one-character payloads to keep runs short
`timescale 1ns/100ps
module bcr_reader #(
   parameter int BIT_CLKS = 2080
) (
   input wire logic clk_in,
   input wire logic permit_in,
   input wire logic data8_in,
   input wire logic stop1_in,
   input wire logic [1:0] par_in,
   output logic txd_out
);
   initial txd_out = 1'b1;

   task automatic put_bit(input logic b);
      txd_out <= b;
      repeat (BIT_CLKS) @(posedge clk_in);
   endtask : put_bit

   // Same framing as the device is set to
   task automatic send_char(input logic [7:0] c);
      logic p;
      p = data8_in ? ^c : ^c[6:0];
      put_bit(1'b0);
      for (int i = 0; i < (data8_in ? 8 : 7); i++) begin
         put_bit(c[i]);
      end
      if (par_in != 2'b00) begin
         put_bit(par_in == 2'b01 ? ~p : p);
      end
      put_bit(1'b1);
      if (!stop1_in) begin
         put_bit(1'b1);
      end
   endtask : send_char

   // Plain frame, no ID or digit count; holds off while not permitted
   // Close low cuts the frame after the data character
   task automatic send_frame(input logic [7:0] b, input logic close);
      int i;
      i = 0;
      while (permit_in !== 1'b1 && i < 10000) begin
         @(posedge clk_in);
         i++;
      end
      if (permit_in === 1'b1) begin
         send_char(8'h02);
         send_char(b);
         if (close) begin
            send_char(8'h03);
         end
      end
   endtask : send_frame
endmodule : bcr_reader

//--- verification/testbench.sv
// Purpose: Self-checking bench of the bar code receiver
// Assumes: Zero-wait AHB-Lite slave; 19200 bps gives 2080 clocks a bit
// Notes: One 7N1 frame and one cut 7E1 frame keep the run under 100k cycles
`timescale 1ns/100ps
module testbench;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] exp;
   } bcr_row_t;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic hsel, hwrite, hready, hresp, rxd, permit, valid;
   logic send_permit, str_ack, data8, stop1;
   logic [1:0] htrans, par;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [5:0] len;
   logic [319:0] sdata;
   int n_errors = 0;
   int n_tests = 0;
   bcr_row_t rows[4] = '{'{8'h00, 32'h18}, '{8'h04, 32'h2}, '{8'h0c, 32'h0}, '{8'h40, 32'h0}};

   always #12.5 clk_in = ~clk_in;

   bcr_top bcr_top_i (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
      .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp), .rxd_in(rxd),
      .send_permit_in(send_permit), .receive_permit_out(permit),
      .str_valid_out(valid), .str_len_out(len), .str_data_out(sdata),
      .str_ack_in(str_ack));

   bcr_reader #(.BIT_CLKS(2080)) bcr_reader_i (.clk_in(clk_in), .permit_in(permit),
      .data8_in(data8), .stop1_in(stop1), .par_in(par), .txd_out(rxd));

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Bounded wait for a level on a design output
   task automatic wait_for(input string what, input logic e, input int lim);
      int i;
      i = 0;
      @(posedge clk_in);
      while ((what == "hready" ? hready : valid) !== e) begin
         i++;
         if (i > lim) begin
            chk(what, {31'h0, e}, {31'h0, ~e});
            test_done;
         end
         @(posedge clk_in);
      end
   endtask : wait_for

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
      @(posedge clk_in);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_for("hready", 1'b1, 50);
      htrans <= 2'b00;
      hwdata <= wd;
      wait_for("hready", 1'b1, 50);
      r = hrdata;
   endtask : ahb

   initial begin
      hsel = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      send_permit = 1'b1;
      str_ack = 1'b0;
      data8 = 1'b0;
      stop1 = 1'b1;
      par = 2'b00;
      repeat (6) @(posedge clk_in);
      chk("permit", 32'h0, {31'h0, permit});
      chk("valid", 32'h0, {31'h0, valid});
      resetn_in <= 1'b1;
      // Read-only and unmapped writes must leave no trace
      ahb(1'b1, 8'h04, 32'hff, rd);
      ahb(1'b1, 8'h0c, 32'hff, rd);
      foreach (rows[k]) begin
         ahb(1'b0, rows[k].addr, 32'h0, rd);
         chk("reg", rows[k].exp, rd);
      end
      chk("hresp", 32'h0, {31'h0, hresp});
      ahb(1'b1, 8'h00, 32'ha2, rd);
      bcr_reader_i.send_frame(8'h7f, 1'b1);
      wait_for("valid", 1'b1, 200);
      @(negedge clk_in);
      chk("len", 32'h1, {26'h0, len});
      chk("byte0", 32'h7f, {24'h0, sdata[7:0]});
      chk("permit manual", 32'h1, {31'h0, permit});
      ahb(1'b0, 8'h40, 32'h0, rd);
      chk("payload reg", 32'h7f, rd);
      ahb(1'b1, 8'h00, 32'he2, rd);
      @(negedge clk_in);
      chk("permit auto", 32'h0, {31'h0, permit});
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk("status", 32'h103, rd);
      @(posedge clk_in);
      str_ack <= 1'b1;
      @(posedge clk_in);
      str_ack <= 1'b0;
      @(negedge clk_in);
      chk("valid ack", 32'h0, {31'h0, valid});
      chk("permit ack", 32'h1, {31'h0, permit});
      // Just below the printable range, even parity, no end character
      par <= 2'b10;
      ahb(1'b1, 8'h00, 32'hea, rd);
      bcr_reader_i.send_frame(8'h1f, 1'b0);
      repeat (20) @(posedge clk_in);
      chk("valid bad", 32'h0, {31'h0, valid});
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk("drop count", 32'h1, {24'h0, rd[23:16]});
      // Reset in mid-run brings back the defaults and closes the port
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(negedge clk_in);
      chk("permit rst", 32'h0, {31'h0, permit});
      chk("valid rst", 32'h0, {31'h0, valid});
      chk("len rst", 32'h0, {26'h0, len});
      ahb(1'b0, 8'h00, 32'h0, rd);
      chk("ctrl rst", 32'h18, rd);
      test_done;
   end
endmodule : testbench
